// ===== src/fsp_regs.vh
// Contract
// RULE1: Three fuse bytes, programmed reads zero
// RULE2: Extended fuse: brownout level, factory bit
// RULE3: High fuse debug, test, serial, watchdog bits
// RULE4: Preserve fuse keeps EEPROM through erase
// RULE5: Boot size bits and reset vector select
// RULE6: Serial enable fuse locked in serial mode
// RULE7: Clock divide by eight, clock output
// RULE8: Startup time and clock source defaults
// RULE9: Chip erase leaves fuses unchanged
// RULE10: Lock bit one blocks fuse changes
// RULE11: Programmer writes fuses before lock bits
// RULE12: Fuses captured on programming mode entry
// RULE13: Preserve fuse takes effect immediately
// RULE14: Fuses also captured at power-up
// RULE15: Three signature bytes, always readable
// RULE16: Trim byte at high byte address zero
// RULE17: Trim byte copied to trim register on reset
// RULE18: Programmer strobes at least 250 ns
// RULE19: Crystal pulse performs selected load action
// RULE20: Write or read strobe runs loaded command
// RULE21: Action select encoding
// RULE22: Command byte encoding
// RULE23: Ready busy low while operation runs
// RULE24: Shadow fuse copy drives configuration
`ifndef FSP_REGS_VH
`define FSP_REGS_VH
`define FSP_EXT_DEFAULT 8'hff
`define FSP_HIGH_DEFAULT 8'h99
`define FSP_LOW_DEFAULT 8'h62
`define FSP_EXT_UNUSED_MASK 8'hf0
`define FSP_SERIAL_PROG_ENABLE_BIT 5
`define FSP_EEPROM_PRESERVE_BIT 3
`define FSP_LB1_BIT 0
`define FSP_LOCK_DEFAULT 8'hff
`define FSP_ACT_ADDR 2'b00
`define FSP_ACT_DATA 2'b01
`define FSP_ACT_CMD 2'b10
`define FSP_ACT_IDLE 2'b11
`define FSP_CMD_ERASE 8'h80
`define FSP_CMD_WFUSE 8'h40
`define FSP_CMD_WLOCK 8'h20
`define FSP_CMD_WFLASH 8'h10
`define FSP_CMD_WEEP 8'h11
`define FSP_CMD_RSIG 8'h08
`define FSP_CMD_RFUSE 8'h04
`define FSP_CMD_RFLASH 8'h02
`define FSP_CMD_REEP 8'h03
`define FSP_SIG_ADDR0 8'h00
`define FSP_SIG_ADDR1 8'h01
`define FSP_SIG_ADDR2 8'h02
`define FSP_BUSY_NS 1000
`define FSP_CLK_NS 4
`define FSP_BUSY_CYC ((`FSP_BUSY_NS + `FSP_CLK_NS - 1) / `FSP_CLK_NS)
`endif

// ===== src/fsp_sync.v
`timescale 1ns/1ps
// Two-flop synchroniser for a group of pin levels
module fsp_sync #(
  parameter W = 1
) (
  input wire mclk,
  input wire resetn,
  input wire [W-1:0] d,
  output reg [W-1:0] q
);
  reg [W-1:0] meta_q;
  always @(posedge mclk) begin
    if (!resetn) begin
      meta_q <= {W{1'b0}};
      q <= {W{1'b0}};
    end else begin
      meta_q <= d;
      q <= meta_q;
    end
  end
endmodule // fsp_sync

// ===== src/fsp_core.v
`timescale 1ns/1ps
`include "fsp_regs.vh"
module fsp_core #(
  parameter [7:0] SIG_BYTE0 = 8'h5a, // Arbitrary value
  parameter [7:0] SIG_BYTE1 = 8'h3c, // Arbitrary value
  parameter [7:0] SIG_BYTE2 = 8'h42, // Arbitrary value
  parameter [7:0] TRIM_BYTE = 8'h80  // Arbitrary value
) (
  input wire mclk,
  input wire resetn,
  input wire prog_mode,
  input wire serial_mode,
  input wire crystal_input_pin,
  input wire action_select_hi,
  input wire action_select_lo,
  input wire byte_select_one,
  input wire byte_select_two,
  input wire write_n,
  input wire out_enable_n,
  input wire [7:0] data_in,
  output reg [7:0] data_out,
  output wire data_oe,
  output wire prog_ready_busy,
  output wire [2:0] brownout_threshold,
  output wire factory_test_bit,
  output wire onchip_debug_enable,
  output wire test_port_enable,
  output wire serial_prog_enable,
  output wire watchdog_force_on,
  output wire eeprom_preserve,
  output wire [1:0] boot_section_size,
  output wire reset_vector_select,
  output wire clock_div_by_eight,
  output wire clock_output_enable,
  output wire [1:0] startup_time_sel,
  output wire [3:0] clock_source_sel,
  output wire memory_lock_bit_one,
  output reg [7:0] rc_osc_trim_reg,
  output reg erase_strobe,
  output reg flash_write_strobe,
  output reg eeprom_write_strobe,
  output reg [15:0] mem_addr,
  output reg [15:0] mem_wdata
);

  // ----------------------------------------------------------------
  // Pin synchronisation
  // ----------------------------------------------------------------
  wire [17:0] pin_s;
  fsp_sync #(.W(18)) u_sync (
    .mclk(mclk),
    .resetn(resetn),
    .d({prog_mode, serial_mode, crystal_input_pin, action_select_hi,
        action_select_lo, byte_select_one, byte_select_two, write_n,
        out_enable_n, data_in, 1'b0}),
    .q(pin_s)
  );
  wire prog_s = pin_s[17];
  wire serial_s = pin_s[16];
  wire xtal_s = pin_s[15];
  wire [1:0] act_s = pin_s[14:13];
  wire bs1_s = pin_s[12];
  wire bs2_s = pin_s[11];
  wire wr_n_s = pin_s[10];
  wire oe_n_s = pin_s[9];
  wire [7:0] din_s = pin_s[8:1];

  // ----------------------------------------------------------------
  // Edge detection
  // ----------------------------------------------------------------
  reg xtal_q, wr_n_q, prog_q;
  always @(posedge mclk) begin
    if (!resetn) begin
      xtal_q <= 1'b0;
      // Matches the synchroniser's reset level, so no false fall
      wr_n_q <= 1'b0;
      prog_q <= 1'b0;
    end else begin
      xtal_q <= xtal_s;
      wr_n_q <= wr_n_s;
      prog_q <= prog_s;
    end
  end
  wire xtal_rise = xtal_s & ~xtal_q;
  wire wr_fall = ~wr_n_s & wr_n_q;
  wire prog_enter = prog_s & ~prog_q;
  wire prog_exit = ~prog_s & prog_q;

  // ----------------------------------------------------------------
  // Nonvolatile store and loaded command state
  // ----------------------------------------------------------------
  localparam ST_IDLE = 1'b0;
  localparam ST_BUSY = 1'b1;

  reg [7:0] fuse_ext_q, fuse_high_q, fuse_low_q, lock_q;
  reg [7:0] cmd_q, addr_lo_q, addr_hi_q, data_lo_q, data_hi_q;
  reg [7:0] shd_ext_q, shd_high_q, shd_low_q;
  reg state_q;
  reg [9:0] busy_cnt_q;
  // Cleared only by a supply cycle; later resets keep the store
  reg nv_init_q = 1'b0;

  // Busy length fits the counter width without truncation
  localparam [9:0] BUSY_LOAD = `FSP_BUSY_CYC - 1;

  function fuse_locked;
    input [7:0] lk;
    begin
      fuse_locked = ~lk[`FSP_LB1_BIT];
    end
  endfunction

  wire busy = (state_q == ST_BUSY);
  wire idle_ok = ~busy & prog_s;
  wire do_write = wr_fall & idle_ok; // see RULE20
  // Serial enable bit keeps its stored value in serial mode
  wire [7:0] serial_prog_enable_keep = serial_s ? (8'h01 << `FSP_SERIAL_PROG_ENABLE_BIT) : 8'h00;

  always @(posedge mclk) begin
    if (!resetn) begin
      // First reset after power-up loads erased store defaults
      if (!nv_init_q) begin
        fuse_ext_q <= `FSP_EXT_DEFAULT; // see RULE2
        fuse_high_q <= `FSP_HIGH_DEFAULT; // see RULE3
        fuse_low_q <= `FSP_LOW_DEFAULT; // see RULE8
        lock_q <= `FSP_LOCK_DEFAULT;
      end
      nv_init_q <= 1'b1;
      cmd_q <= 8'h00;
      addr_lo_q <= 8'h00;
      addr_hi_q <= 8'h00;
      data_lo_q <= 8'h00;
      data_hi_q <= 8'h00;
      state_q <= ST_IDLE;
      busy_cnt_q <= 10'h000;
      erase_strobe <= 1'b0;
      flash_write_strobe <= 1'b0;
      eeprom_write_strobe <= 1'b0;
    end else begin
      erase_strobe <= 1'b0;
      flash_write_strobe <= 1'b0;
      eeprom_write_strobe <= 1'b0;
      if (xtal_rise && prog_s && !busy) begin // see RULE19
        case (act_s) // see RULE21
          `FSP_ACT_ADDR: begin
            if (bs1_s) addr_hi_q <= din_s;
            else addr_lo_q <= din_s;
          end
          `FSP_ACT_DATA: begin
            if (bs1_s) data_hi_q <= din_s;
            else data_lo_q <= din_s;
          end
          `FSP_ACT_CMD: cmd_q <= din_s;
          default: ;
        endcase
      end
      case (state_q)
        ST_IDLE: begin
          if (do_write) begin
            state_q <= ST_BUSY;
            busy_cnt_q <= BUSY_LOAD;
            case (cmd_q) // see RULE22
              `FSP_CMD_ERASE: begin
                erase_strobe <= 1'b1; // see RULE4
                lock_q <= `FSP_LOCK_DEFAULT; // fuses untouched, see RULE9
              end
              `FSP_CMD_WFUSE: begin
                if (!fuse_locked(lock_q)) begin // see RULE10
                  case ({bs2_s, bs1_s}) // see RULE1
                    2'b00: fuse_low_q <= data_lo_q;
                    2'b01: fuse_high_q <= (data_lo_q & ~serial_prog_enable_keep) |
                                          (fuse_high_q & serial_prog_enable_keep); // see RULE6
                    2'b10: fuse_ext_q <= data_lo_q |
                                         `FSP_EXT_UNUSED_MASK; // see RULE2
                    default: ;
                  endcase
                end
              end
              `FSP_CMD_WLOCK: lock_q <= lock_q & data_lo_q;
              `FSP_CMD_WFLASH: flash_write_strobe <= 1'b1;
              `FSP_CMD_WEEP: eeprom_write_strobe <= 1'b1;
              default: state_q <= ST_IDLE;
            endcase
          end
        end
        ST_BUSY: begin
          if (busy_cnt_q == 10'h000) state_q <= ST_IDLE;
          else busy_cnt_q <= busy_cnt_q - 10'd1;
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  assign prog_ready_busy = ~busy; // see RULE23

  always @(posedge mclk) begin
    if (!resetn) begin
      mem_addr <= 16'h0000;
      mem_wdata <= 16'h0000;
    end else begin
      mem_addr <= {addr_hi_q, addr_lo_q};
      mem_wdata <= {data_hi_q, data_lo_q};
    end
  end

  // ----------------------------------------------------------------
  // Shadow fuses and oscillator trim
  // ----------------------------------------------------------------
  reg cap_pending_q;
  always @(posedge mclk) begin
    if (!resetn) begin
      shd_ext_q <= `FSP_EXT_DEFAULT;
      shd_high_q <= `FSP_HIGH_DEFAULT;
      shd_low_q <= `FSP_LOW_DEFAULT;
      rc_osc_trim_reg <= TRIM_BYTE; // see RULE17
      cap_pending_q <= 1'b1;
    end else begin
      cap_pending_q <= 1'b0;
      // Store read one cycle after reset release, see RULE14
      if (cap_pending_q || prog_enter || prog_exit) begin // see RULE12
        shd_ext_q <= fuse_ext_q; // see RULE24
        shd_high_q <= fuse_high_q;
        shd_low_q <= fuse_low_q;
      end
    end
  end

  // ----------------------------------------------------------------
  // Configuration outputs
  // ----------------------------------------------------------------
  assign brownout_threshold = shd_ext_q[3:1];
  assign factory_test_bit = shd_ext_q[0];
  assign onchip_debug_enable = shd_high_q[7]; // see RULE3
  assign test_port_enable = shd_high_q[6];
  assign serial_prog_enable = shd_high_q[5];
  assign watchdog_force_on = shd_high_q[4];
  // Preserve bit bypasses the shadow latch
  assign eeprom_preserve = fuse_high_q[`FSP_EEPROM_PRESERVE_BIT]; // see RULE13
  assign boot_section_size = shd_high_q[2:1]; // see RULE5
  assign reset_vector_select = shd_high_q[0];
  assign clock_div_by_eight = shd_low_q[7]; // see RULE7
  assign clock_output_enable = shd_low_q[6];
  assign startup_time_sel = shd_low_q[5:4]; // see RULE8
  assign clock_source_sel = shd_low_q[3:0];
  assign memory_lock_bit_one = lock_q[`FSP_LB1_BIT];

  // ----------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------
  function [7:0] sig_read;
    input [7:0] a;
    input hi;
    begin
      if (hi) sig_read = (a == `FSP_SIG_ADDR0) ? TRIM_BYTE : 8'hff;
      else case (a) // see RULE15
        `FSP_SIG_ADDR0: sig_read = SIG_BYTE0;
        `FSP_SIG_ADDR1: sig_read = SIG_BYTE1;
        `FSP_SIG_ADDR2: sig_read = SIG_BYTE2;
        default: sig_read = 8'hff;
      endcase
    end
  endfunction

  always @(posedge mclk) begin
    if (!resetn) begin
      data_out <= 8'h00;
    end else if (!oe_n_s) begin // see RULE20
      case (cmd_q)
        `FSP_CMD_RSIG: data_out <= sig_read(addr_lo_q, bs1_s); // see RULE16
        `FSP_CMD_RFUSE: begin
          case ({bs2_s, bs1_s})
            2'b00: data_out <= fuse_low_q;
            2'b11: data_out <= fuse_high_q;
            2'b10: data_out <= fuse_ext_q;
            default: data_out <= lock_q;
          endcase
        end
        default: data_out <= 8'hff;
      endcase
    end
  end
  assign data_oe = prog_s & ~oe_n_s;
endmodule // fsp_core

// ===== testbench/fsp_chk.sv
`timescale 1ns/1ps
module fsp_chk #(
  parameter [7:0] TRIM_BYTE = 8'h80
) (
  input wire mclk,
  input wire resetn,
  input wire prog_mode,
  input wire out_enable_n,
  input wire data_oe,
  input wire prog_ready_busy,
  input wire [2:0] brownout_threshold,
  input wire [1:0] boot_section_size,
  input wire [3:0] clock_source_sel,
  input wire clock_div_by_eight,
  input wire [7:0] rc_osc_trim_reg,
  input wire erase_strobe,
  input wire flash_write_strobe,
  input wire eeprom_write_strobe
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!resetn);
  // ----
  // Busy length
  // ----
  logic [9:0] busy_q;
  always @(posedge mclk) begin
    if (!resetn || prog_ready_busy) busy_q <= 10'h0;
    else busy_q <= busy_q + 10'h1;
  end
  // Reset release recaptures the store, so it breaks steadiness too
  sequence s_mode_steady;
    ($stable(prog_mode) && $stable(resetn))[*5];
  endsequence
  sequence s_busy_ends; $rose(prog_ready_busy); endsequence
  a_busy_span: assert property (s_busy_ends |-> busy_q >= 10'hf9 && busy_q <= 10'hfb)
    else $error("busy span wrong");
  a_ready_reset: assert property ($rose(resetn) |-> prog_ready_busy)
    else $error("not ready after reset");
  a_trim_reset: assert property ($rose(resetn) |-> rc_osc_trim_reg == TRIM_BYTE)
    else $error("trim not loaded");
  a_shadow_held: assert property (s_mode_steady |-> $stable({brownout_threshold,
    boot_section_size, clock_source_sel, clock_div_by_eight}))
    else $error("shadow moved");
  a_oe_idle: assert property (out_enable_n[*4] |-> !data_oe)
    else $error("bus driven without read");
  a_strobe_alone: assert property ($onehot0({erase_strobe,
    flash_write_strobe, eeprom_write_strobe}))
    else $error("strobes overlap");
  a_erase_pulse: assert property (erase_strobe |=> !erase_strobe)
    else $error("erase strobe too long");
  a_erase_busy: assert property (erase_strobe |-> ##[0:3] !prog_ready_busy)
    else $error("erase without busy");
endmodule // fsp_chk
bind fsp_core fsp_chk #(.TRIM_BYTE(TRIM_BYTE)) i_fsp_chk (.mclk(mclk),
  .resetn(resetn), .prog_mode(prog_mode), .out_enable_n(out_enable_n),
  .data_oe(data_oe), .prog_ready_busy(prog_ready_busy),
  .brownout_threshold(brownout_threshold),
  .boot_section_size(boot_section_size), .clock_source_sel(clock_source_sel),
  .clock_div_by_eight(clock_div_by_eight), .rc_osc_trim_reg(rc_osc_trim_reg),
  .erase_strobe(erase_strobe), .flash_write_strobe(flash_write_strobe),
  .eeprom_write_strobe(eeprom_write_strobe));

// ===== testbench/fsp_prog.sv
`timescale 1ns/1ps
module fsp_prog (
  input wire mclk,
  input wire prog_ready_busy,
  input wire [7:0] data_out,
  output logic crystal_input_pin = 1'b0,
  output logic action_select_hi = 1'b1,
  output logic action_select_lo = 1'b1,
  output logic byte_select_one = 1'b0,
  output logic byte_select_two = 1'b0,
  output logic write_n = 1'b1,
  output logic out_enable_n = 1'b1,
  output logic [7:0] data_in = 8'h00
);
  // ----
  // Strobes
  // ----
  // 64 cycles is just over the minimum pulse; slow but always legal
  task automatic gap();
    repeat (64) @(posedge mclk);
  endtask
  task automatic load(input logic [1:0] a, input logic b, input logic [7:0] d);
    @(posedge mclk);
    {action_select_hi, action_select_lo} <= a;
    byte_select_one <= b;
    data_in <= d;
    gap();
    crystal_input_pin <= 1'b1;
    gap();
    crystal_input_pin <= 1'b0;
    gap();
    {action_select_hi, action_select_lo} <= 2'b11;
    data_in <= ~d; // Released bus must not keep its old value
  endtask
  task automatic wr(input logic [1:0] bs, output logic busy);
    @(posedge mclk);
    {byte_select_two, byte_select_one} <= bs;
    gap();
    write_n <= 1'b0;
    gap();
    busy = !prog_ready_busy;
    write_n <= 1'b1;
    for (int i = 0; i < 400 && !prog_ready_busy; i++) @(posedge mclk);
    gap();
  endtask
  task automatic rd(input logic [1:0] bs, output logic [7:0] d);
    @(posedge mclk);
    {byte_select_two, byte_select_one} <= bs;
    gap();
    out_enable_n <= 1'b0;
    gap();
    d = data_out;
    out_enable_n <= 1'b1;
    gap();
  endtask
endmodule // fsp_prog

// ===== testbench/fsp_core_bench.sv
`timescale 1ns/1ps
module fsp_core_bench;
  logic mclk = 1'b0;
  logic resetn = 1'b0;
  logic prog_mode = 1'b0;
  logic serial_mode = 1'b0;
  wire xtal, ahi, alo, bs1, bs2, wr_n, oe_n, oe, rdy, pres, lock1;
  wire fac, ocd, tpe, spe, wdt, rvs, ck8, cko;
  wire [7:0] din, dout, trim;
  wire [2:0] bod;
  wire [1:0] boot, sut;
  wire [3:0] cks;
  wire [19:0] cfg = {bod, fac, ocd, tpe, spe, wdt, pres, boot, rvs, ck8, cko,
    sut, cks};
  logic [7:0] sig [3] = '{8'h11, 8'h22, 8'h33};
  logic [7:0] rv;
  logic bz;
  int error_cnt = 0;
  int tests_run = 0;
  always #2 mclk = ~mclk;
  fsp_core #(.SIG_BYTE0(8'h11), .SIG_BYTE1(8'h22), .SIG_BYTE2(8'h33),
    .TRIM_BYTE(8'h44)) i_fsp_core (.mclk(mclk), .resetn(resetn),
    .prog_mode(prog_mode), .serial_mode(serial_mode), .crystal_input_pin(xtal),
    .action_select_hi(ahi), .action_select_lo(alo), .byte_select_one(bs1),
    .byte_select_two(bs2), .write_n(wr_n), .out_enable_n(oe_n),
    .data_in(din), .data_out(dout), .data_oe(oe), .prog_ready_busy(rdy),
    .brownout_threshold(bod), .factory_test_bit(fac),
    .onchip_debug_enable(ocd), .test_port_enable(tpe),
    .serial_prog_enable(spe), .watchdog_force_on(wdt),
    .eeprom_preserve(pres), .boot_section_size(boot),
    .reset_vector_select(rvs), .clock_div_by_eight(ck8),
    .clock_output_enable(cko), .startup_time_sel(sut),
    .clock_source_sel(cks), .memory_lock_bit_one(lock1),
    .rc_osc_trim_reg(trim), .erase_strobe(), .flash_write_strobe(),
    .eeprom_write_strobe(), .mem_addr(), .mem_wdata());
  fsp_prog i_fsp_prog (.mclk(mclk), .prog_ready_busy(rdy), .data_out(dout),
    .crystal_input_pin(xtal), .action_select_hi(ahi), .action_select_lo(alo),
    .byte_select_one(bs1), .byte_select_two(bs2), .write_n(wr_n),
    .out_enable_n(oe_n), .data_in(din));
  // ----
  // Tasks
  // ----
  task automatic chk(input string n, input logic [19:0] e, input logic [19:0] s);
    tests_run++;
    if (s !== e) begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic close_out();
    $display("checks %0d mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic cmd(input logic [7:0] c);
    i_fsp_prog.load(2'b10, 1'b0, c);
  endtask
  task automatic rdf(input logic [1:0] bs, input logic [7:0] e);
    i_fsp_prog.rd(bs, rv);
    chk("read", {12'h0, e}, {12'h0, rv});
  endtask
  task automatic wf(input logic [1:0] bs, input logic [7:0] d);
    i_fsp_prog.load(2'b01, 1'b0, d);
    i_fsp_prog.wr(bs, bz);
  endtask
  task automatic mode(input logic m);
    prog_mode <= m;
    repeat (8) @(posedge mclk);
  endtask
  // ----
  // Sequence
  // ----
  initial begin
    repeat (3) @(posedge mclk);
    resetn <= 1'b1;
    repeat (6) @(posedge mclk);
    chk("cfg", 20'hf9962, cfg);
    chk("trim", 20'h44, {12'h0, trim});
    mode(1'b1);
    cmd(8'h04);
    rdf(2'b00, 8'h62);
    rdf(2'b11, 8'h99);
    rdf(2'b10, 8'hff);
    rdf(2'b01, 8'hff);
    cmd(8'h08);
    for (int i = 0; i < 3; i++) begin
      i_fsp_prog.load(2'b00, 1'b0, 8'(i));
      rdf(2'b00, sig[i]);
    end
    i_fsp_prog.load(2'b00, 1'b0, 8'h00);
    rdf(2'b01, 8'h44);
    cmd(8'h40);
    wf(2'b00, 8'he2);
    chk("busy", 20'h1, {19'h0, bz});
    wf(2'b10, 8'h05);
    serial_mode <= 1'b1;
    wf(2'b01, 8'hb1);
    serial_mode <= 1'b0;
    chk("preserve", 20'h0, {19'h0, pres});
    chk("cfg", 20'hf9162, cfg);
    cmd(8'h04);
    rdf(2'b00, 8'he2);
    rdf(2'b11, 8'h91);
    rdf(2'b10, 8'hf5);
    cmd(8'h80);
    i_fsp_prog.wr(2'b00, bz);
    cmd(8'h04);
    rdf(2'b00, 8'he2);
    mode(1'b0);
    chk("cfg", 20'h591e2, cfg);
    mode(1'b1);
    cmd(8'h20);
    wf(2'b00, 8'hfe);
    chk("lock", 20'h0, {19'h0, lock1});
    cmd(8'h40);
    wf(2'b00, 8'h62);
    cmd(8'h04);
    rdf(2'b00, 8'he2);
    resetn <= 1'b0;
    prog_mode <= 1'b0;
    repeat (3) @(posedge mclk);
    resetn <= 1'b1;
    repeat (6) @(posedge mclk);
    chk("cfg", 20'h591e2, cfg);
    close_out();
  end
  initial begin
    repeat (60000) @(posedge mclk);
    error_cnt++;
    close_out();
  end
endmodule // fsp_core_bench
